// ===== evpu_pkg.sv
// Constants and types for the exception vector and priority unit.
// Assumes a 16-bit core whose vectors live at $FFxx and a 32-bit register bus.
package evpu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] EVPU_IDX_INT_CTRL = 8'h1E;
  localparam logic [7:0] EVPU_IDX_PRIO_ELEV = 8'h1F;
  localparam logic [7:0] EVPU_IDX_PENDING = 8'h20;
  localparam logic [7:0] EVPU_IDX_LAST_VEC = 8'h21;

  // Interrupt control fields
  localparam int EVPU_BIT_EDGE_SEL = 7;
  localparam int EVPU_BIT_PIN_CONN = 6;
  localparam int EVPU_BIT_STOP_DLY = 5;
  localparam logic EVPU_RST_EDGE_SEL = 1'b0;
  localparam logic EVPU_RST_PIN_CONN = 1'b1;
  localparam logic EVPU_RST_STOP_DLY = 1'b1;

  localparam logic [7:0] EVPU_RST_PRIO_ELEV = 8'hF2;
  localparam logic [7:0] EVPU_MAX_MASKABLE = 8'hF2;
  localparam logic [7:0] EVPU_VEC_HIGH_BYTE = 8'hFF;

  // Fixed vectors
  localparam logic [15:0] EVPU_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] EVPU_VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] EVPU_VEC_WDOG = 16'hFFFA;
  localparam logic [15:0] EVPU_VEC_TRAP = 16'hFFF8;
  localparam logic [15:0] EVPU_VEC_SOFT = 16'hFFF6;
  localparam logic [15:0] EVPU_VEC_NMI = 16'hFFF4;

  // Maskable sources: index 0 is the external pin, 1..15 the peripherals
  localparam int EVPU_NUM_SRC = 16;
  localparam int EVPU_NUM_PERIPH = EVPU_NUM_SRC - 1;
  localparam logic [7:0] EVPU_SRC_VEC [EVPU_NUM_SRC] = '{
    8'hF2, 8'hF0, 8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4,
    8'hE2, 8'hE0, 8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD2};

  // Stop-exit oscillator settle time, in E-clock cycles
  localparam int EVPU_STOP_DLY_CYCLES = 4096;

  typedef struct packed {
    logic edge_sel;
    logic pin_conn;
    logic stop_dly;
  } evpu_ctrl_t;

  typedef struct packed {
    logic [15:0] addr;
    logic valid;
  } evpu_vec_t;

  typedef enum logic [1:0] {EVPU_ST_BOOT, EVPU_ST_RUN, EVPU_ST_STOP_WAIT} evpu_state_t;

endpackage

// ===== evpu_top.sv
// Exception vector and priority unit: vector selection, pin latching,
// interrupt control and priority-elevation registers on an Avalon-MM slave.
// Assumes peripherals hold their own flags and the CPU stacks registers.
`timescale 1ns/1ps
module evpu_top
  import evpu_pkg::*;
#(
  parameter int STOP_DLY_CYC = EVPU_STOP_DLY_CYCLES,
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SPECIAL_MODE,
  input wire logic CLKMON_CAUSE,
  input wire logic WDOG_CAUSE,
  input wire logic CPU_I_MASK,
  input wire logic CPU_X_MASK,
  input wire logic SVC_START,
  input wire logic SOFT_INT_EXEC,
  input wire logic ILLEGAL_OP,
  input wire logic STOP_WAKE,
  input wire logic EXT_INT_PIN_N,
  input wire logic NONMASKABLE_EXT_INT_PIN_N,
  input wire logic [EVPU_NUM_PERIPH-1:0] PERIPH_FLAG,
  input wire logic [EVPU_NUM_PERIPH-1:0] PERIPH_EN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic INT_REQ,
  output logic NMI_REQ,
  output logic [15:0] VECTOR,
  output logic VECTOR_VALID,
  output logic STOP_RELEASE
);

  if (ADDR_W < 8) begin : g_chk_addr
    $error("ADDR_W must hold the register indices");
  end
  if (STOP_DLY_CYC < 1 || STOP_DLY_CYC > 65535) begin : g_chk_dly
    $error("STOP_DLY_CYC out of counter range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta;
  logic rst_sync;

  // Entry is asynchronous; release needs two clock edges
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Source index for a vector byte; the pin when nothing matches
  function automatic logic [3:0] elev_index(input logic [7:0] b);
    logic [3:0] idx;
    idx = 4'h0;
    if (b <= EVPU_MAX_MASKABLE) begin
      for (int i = 0; i < EVPU_NUM_SRC; i++) begin
        if (EVPU_SRC_VEC[i] == b) begin
          idx = 4'(i);
        end
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] full_vec(input logic [3:0] idx);
    return {EVPU_VEC_HIGH_BYTE, EVPU_SRC_VEC[idx]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [ADDR_W-1:0] addr_hit;
  logic bus_req;
  logic wr_commit;
  logic wr_ctrl;
  logic wr_elev;

  evpu_ctrl_t ctrl;
  evpu_ctrl_t next_ctrl;
  logic edge_seen;
  logic next_edge_seen;
  logic dly_seen;
  logic next_dly_seen;
  logic [7:0] prio_elev;
  logic [7:0] next_prio_elev;
  logic special;
  logic next_special;
  logic [31:0] next_readdata;
  logic next_waitreq;

  assign addr_hit = AVS_ADDRESS;
  assign bus_req = AVS_READ | AVS_WRITE;
  // A write lands at the edge where the master sees waitrequest low
  assign wr_commit = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  assign wr_ctrl = wr_commit && addr_hit == ADDR_W'(EVPU_IDX_INT_CTRL);
  assign wr_elev = wr_commit && addr_hit == ADDR_W'(EVPU_IDX_PRIO_ELEV);

  logic [EVPU_NUM_SRC-1:0] pend;
  logic [15:0] last_vec;
  evpu_state_t state;

  always_comb begin
    next_ctrl = ctrl;
    next_edge_seen = edge_seen;
    next_dly_seen = dly_seen;
    next_prio_elev = prio_elev;
    next_special = special;
    if (state == EVPU_ST_BOOT) begin
      next_special = SPECIAL_MODE;
    end
    if (wr_ctrl) begin
      next_edge_seen = 1'b1;
      next_dly_seen = 1'b1;
      // Normal modes take only the first write; special modes drop it
      if (special ? edge_seen : !edge_seen) begin
        next_ctrl.edge_sel = AVS_WRITEDATA[EVPU_BIT_EDGE_SEL];
      end
      next_ctrl.pin_conn = AVS_WRITEDATA[EVPU_BIT_PIN_CONN];
      if (special || !dly_seen) begin
        next_ctrl.stop_dly = AVS_WRITEDATA[EVPU_BIT_STOP_DLY];
      end
    end
    if (wr_elev && CPU_I_MASK) begin
      next_prio_elev = AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      ctrl <= '{EVPU_RST_EDGE_SEL, EVPU_RST_PIN_CONN, EVPU_RST_STOP_DLY};
      edge_seen <= 1'b0;
      dly_seen <= 1'b0;
      prio_elev <= EVPU_RST_PRIO_ELEV;
      special <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      edge_seen <= next_edge_seen;
      dly_seen <= next_dly_seen;
      prio_elev <= next_prio_elev;
      special <= next_special;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, read data sampled with waitrequest low

  always_comb begin
    next_waitreq = 1'b1;
    next_readdata = AVS_READDATA;
    if (bus_req && AVS_WAITREQUEST) begin
      next_waitreq = 1'b0;
      next_readdata = 32'h0000_0000;
      unique case (addr_hit)
        ADDR_W'(EVPU_IDX_INT_CTRL): begin
          next_readdata[EVPU_BIT_EDGE_SEL] = ctrl.edge_sel;
          next_readdata[EVPU_BIT_PIN_CONN] = ctrl.pin_conn;
          next_readdata[EVPU_BIT_STOP_DLY] = ctrl.stop_dly;
        end
        ADDR_W'(EVPU_IDX_PRIO_ELEV): next_readdata[7:0] = prio_elev;
        ADDR_W'(EVPU_IDX_PENDING): next_readdata[EVPU_NUM_SRC-1:0] = pend;
        ADDR_W'(EVPU_IDX_LAST_VEC): next_readdata[15:0] = last_vec;
        // Unmapped indices still answer so a stray access cannot hang the master
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= next_waitreq;
      AVS_READDATA <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request gathering and priority

  logic pin_prev;
  logic next_pin_prev;
  logic edge_latch;
  logic next_edge_latch;
  logic pin_req;
  logic [3:0] elev_idx;
  logic [3:0] win_idx;
  logic win_any;

  // Inputs are synchronous to CLK; a one-cycle low is latched only when edge_sel is set
  assign pin_req = ctrl.pin_conn &
    (ctrl.edge_sel ? edge_latch : ~EXT_INT_PIN_N);

  // Peripheral flags are live levels held by the peripherals themselves
  assign pend = {PERIPH_FLAG & PERIPH_EN, pin_req};
  assign elev_idx = elev_index(prio_elev);

  always_comb begin
    win_idx = 4'h0;
    win_any = 1'b0;
    // Lowest index has the highest vector
    for (int i = EVPU_NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win_idx = 4'(i);
        win_any = 1'b1;
      end
    end
    // Elevation overrides the fixed order only while that source is pending
    if (pend[elev_idx]) begin
      win_idx = elev_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception sequencing

  logic ext_serviced;
  logic [15:0] stop_cnt;
  logic [15:0] next_stop_cnt;
  evpu_state_t next_state;
  evpu_vec_t next_vec;
  logic [15:0] next_last_vec;
  logic next_int_req;
  logic next_nmi_req;
  logic next_stop_rel;

  always_comb begin
    next_pin_prev = EXT_INT_PIN_N;
    next_edge_latch = edge_latch;
    // Clear loses to a new edge in the same cycle
    if (ext_serviced) begin
      next_edge_latch = 1'b0;
    end
    if (ctrl.edge_sel && pin_prev && !EXT_INT_PIN_N) begin
      next_edge_latch = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_vec.addr = VECTOR;
    next_vec.valid = 1'b0;
    next_last_vec = last_vec;
    next_stop_cnt = stop_cnt;
    next_stop_rel = 1'b0;
    ext_serviced = 1'b0;
    next_int_req = win_any & ~CPU_I_MASK;
    next_nmi_req = ~NONMASKABLE_EXT_INT_PIN_N & ~CPU_X_MASK;
    unique case (state)
      EVPU_ST_BOOT: begin
        next_vec.valid = 1'b1;
        if (CLKMON_CAUSE) begin
          next_vec.addr = EVPU_VEC_CLKMON;
        end else if (WDOG_CAUSE) begin
          next_vec.addr = EVPU_VEC_WDOG;
        end else begin
          next_vec.addr = EVPU_VEC_RESET;
        end
        next_state = EVPU_ST_RUN;
      end
      EVPU_ST_RUN: begin
        if (ILLEGAL_OP) begin
          next_vec = '{EVPU_VEC_TRAP, 1'b1};
        end else if (SOFT_INT_EXEC) begin
          next_vec = '{EVPU_VEC_SOFT, 1'b1};
        end else if (SVC_START) begin
          next_vec.valid = 1'b1;
          if (!NONMASKABLE_EXT_INT_PIN_N && !CPU_X_MASK) begin
            next_vec.addr = EVPU_VEC_NMI;
          end else if (win_any && !CPU_I_MASK) begin
            next_vec.addr = full_vec(win_idx);
            ext_serviced = (win_idx == 4'h0);
          end else begin
            // Source vanished before the vector fetch
            next_vec.addr = EVPU_VEC_TRAP;
          end
        end else if (STOP_WAKE) begin
          if (ctrl.stop_dly) begin
            next_stop_cnt = 16'(STOP_DLY_CYC - 1);
            next_state = EVPU_ST_STOP_WAIT;
          end else begin
            next_stop_rel = 1'b1;
          end
        end
      end
      EVPU_ST_STOP_WAIT: begin
        // Settle time runs in whole cycles of this clock
        if (stop_cnt == 16'h0000) begin
          next_stop_rel = 1'b1;
          next_state = EVPU_ST_RUN;
        end else begin
          next_stop_cnt = stop_cnt - 16'h0001;
        end
      end
      default: begin
        // Unused state code: fall back to normal running
        next_state = EVPU_ST_RUN;
      end
    endcase
    if (next_vec.valid) begin
      next_last_vec = next_vec.addr;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= EVPU_ST_BOOT;
      pin_prev <= 1'b1;
      edge_latch <= 1'b0;
      stop_cnt <= 16'h0000;
      VECTOR <= EVPU_VEC_RESET;
      VECTOR_VALID <= 1'b0;
      last_vec <= EVPU_VEC_RESET;
      INT_REQ <= 1'b0;
      NMI_REQ <= 1'b0;
      STOP_RELEASE <= 1'b0;
    end else begin
      state <= next_state;
      pin_prev <= next_pin_prev;
      edge_latch <= next_edge_latch;
      stop_cnt <= next_stop_cnt;
      VECTOR <= next_vec.addr;
      VECTOR_VALID <= next_vec.valid;
      last_vec <= next_last_vec;
      INT_REQ <= next_int_req;
      NMI_REQ <= next_nmi_req;
      STOP_RELEASE <= next_stop_rel;
    end
  end

endmodule

// ===== evpu_props.sv
// Concurrent checks on the evpu_top ports.
// Assumes the bench sends no service pulse during a stop wait.
`timescale 1ns/1ps
module evpu_props
  import evpu_pkg::*;
#(
  parameter int STOP_DLY_CYC = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CPU_I_MASK,
  input wire logic CPU_X_MASK,
  input wire logic SVC_START,
  input wire logic SOFT_INT_EXEC,
  input wire logic ILLEGAL_OP,
  input wire logic STOP_WAKE,
  input wire logic NONMASKABLE_EXT_INT_PIN_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic INT_REQ,
  input wire logic NMI_REQ,
  input wire logic [15:0] VECTOR,
  input wire logic VECTOR_VALID,
  input wire logic STOP_RELEASE
);
  logic [2:0] up;
  logic [2:0] next_up;
  // Internal reset lags RST_N by two flops, so checks wait a few edges
  always_comb begin
    next_up = (up == 3'h5) ? up : up + 3'h1;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      up <= 3'h0;
    end else begin
      up <= next_up;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N || up != 3'h5);
  ////////////////////////////////////////
  AST_WAIT_ONE: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  AST_WAIT_DROP: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait request low too long");
  AST_TRAP_VEC: assert property (
    ILLEGAL_OP |=> VECTOR_VALID && VECTOR == EVPU_VEC_TRAP)
    else $error("trap vector wrong");
  AST_SOFT_VEC: assert property (
    SOFT_INT_EXEC && !ILLEGAL_OP |=> VECTOR_VALID && VECTOR == EVPU_VEC_SOFT)
    else $error("soft vector wrong");
  AST_NMI_VEC: assert property (
    SVC_START && !ILLEGAL_OP && !SOFT_INT_EXEC && !NONMASKABLE_EXT_INT_PIN_N && !CPU_X_MASK
    && !$past(NONMASKABLE_EXT_INT_PIN_N) && !$past(CPU_X_MASK) |=> VECTOR == EVPU_VEC_NMI)
    else $error("nmi vector wrong");
  AST_NMI_REQ: assert property (
    NMI_REQ == (!$past(NONMASKABLE_EXT_INT_PIN_N) && !$past(CPU_X_MASK)))
    else $error("nmi request wrong");
  AST_I_MASK: assert property (
    CPU_I_MASK |=> !INT_REQ)
    else $error("request while masked");
  AST_STOP: assert property (
    STOP_RELEASE |-> $past(STOP_WAKE) || $past(STOP_WAKE, STOP_DLY_CYC + 1))
    else $error("stop release at wrong time");
endmodule

// ===== evpu_far.sv
// Far side: peripheral flag sources and the maskable pin driver.
// Assumes the bench raises and clears flags as service software would.
`timescale 1ns/1ps
module evpu_far
  import evpu_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [EVPU_NUM_PERIPH-1:0] raise,
  input wire logic [EVPU_NUM_PERIPH-1:0] clear,
  input wire logic pin_lo,
  input wire logic pin_rel,
  input wire logic [15:0] vec,
  input wire logic vec_valid,
  output logic [EVPU_NUM_PERIPH-1:0] flag,
  output logic pin_n
);
  logic [EVPU_NUM_PERIPH-1:0] next_flag;
  logic next_pin_n;
  ////////////////////////////////////////
  always_comb begin
    next_flag = (flag | raise) & ~clear;
    next_pin_n = pin_n;
    if (pin_lo) begin
      next_pin_n = 1'b0;
    // A level source lets go on pin_rel or once its own vector was fetched
    end else if (pin_rel ||
      (vec_valid && vec == {EVPU_VEC_HIGH_BYTE, EVPU_SRC_VEC[0]})) begin
      next_pin_n = 1'b1;
    end
  end
  // Released pin rests high on its pull-up
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag <= '0;
      pin_n <= 1'b1;
    end else begin
      flag <= next_flag;
      pin_n <= next_pin_n;
    end
  end
endmodule

// ===== tb.sv
// Self-checking bench for evpu_top beside the far-side model.
// Assumes one 50 MHz clock and the stop settle count cut to 8.
`timescale 1ns/1ps
module tb;
  import evpu_pkg::*;
  localparam int STOP_DLY_CYC = 8;
  logic CLK = 1'b0, RST_N = 1'b0, SPECIAL_MODE = 1'b0, CLKMON_CAUSE = 1'b0, WDOG_CAUSE = 1'b0;
  logic CPU_I_MASK = 1'b1, CPU_X_MASK = 1'b1, SVC_START = 1'b0, SOFT_INT_EXEC = 1'b0;
  logic ILLEGAL_OP = 1'b0, STOP_WAKE = 1'b0, NONMASKABLE_EXT_INT_PIN_N = 1'b1;
  logic pin_lo = 1'b0, pin_rel = 1'b0, EXT_INT_PIN_N, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [14:0] PERIPH_EN = 15'h0, raise = 15'h0, clear = 15'h0, PERIPH_FLAG;
  logic [7:0] AVS_ADDRESS = 8'h00, hp;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, lfsr = 32'h91C6;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic AVS_WAITREQUEST, INT_REQ, NMI_REQ, VECTOR_VALID, STOP_RELEASE;
  logic [15:0] VECTOR, pend;
  int num_errors = 0, cmp_count = 0;
  evpu_top #(.STOP_DLY_CYC(STOP_DLY_CYC)) dut (
    .CLK(CLK), .RST_N(RST_N), .SPECIAL_MODE(SPECIAL_MODE), .CLKMON_CAUSE(CLKMON_CAUSE),
    .WDOG_CAUSE(WDOG_CAUSE), .CPU_I_MASK(CPU_I_MASK), .CPU_X_MASK(CPU_X_MASK),
    .SVC_START(SVC_START), .SOFT_INT_EXEC(SOFT_INT_EXEC), .ILLEGAL_OP(ILLEGAL_OP),
    .STOP_WAKE(STOP_WAKE), .EXT_INT_PIN_N(EXT_INT_PIN_N),
    .NONMASKABLE_EXT_INT_PIN_N(NONMASKABLE_EXT_INT_PIN_N), .PERIPH_FLAG(PERIPH_FLAG),
    .PERIPH_EN(PERIPH_EN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .INT_REQ(INT_REQ),
    .NMI_REQ(NMI_REQ), .VECTOR(VECTOR), .VECTOR_VALID(VECTOR_VALID),
    .STOP_RELEASE(STOP_RELEASE));
  evpu_far u_far (.CLK(CLK), .RST_N(RST_N), .raise(raise), .clear(clear), .pin_lo(pin_lo),
    .pin_rel(pin_rel), .vec(VECTOR), .vec_valid(VECTOR_VALID), .flag(PERIPH_FLAG),
    .pin_n(EXT_INT_PIN_N));
  always #10 CLK = ~CLK;
  ////////////////////////////////////////
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Elevated source first if pending, else highest vector, else trap
  function automatic logic [15:0] win(input logic [15:0] p, input logic [7:0] h);
    int e;
    e = 0;
    for (int k = 0; k < EVPU_NUM_SRC; k++)
      if (EVPU_SRC_VEC[k] == h) e = k;
    if (p[e]) return {EVPU_VEC_HIGH_BYTE, EVPU_SRC_VEC[e]};
    for (int k = 0; k < EVPU_NUM_SRC; k++)
      if (p[k]) return {EVPU_VEC_HIGH_BYTE, EVPU_SRC_VEC[k]};
    return EVPU_VEC_TRAP;
  endfunction
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    chk("waitrequest", AVS_WAITREQUEST, 32'h0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("register", q, e);
  endtask
  task automatic fire(input logic [2:0] v, input logic [15:0] e);
    @(posedge CLK);
    {ILLEGAL_OP, SOFT_INT_EXEC, SVC_START} <= v;
    @(posedge CLK);
    {ILLEGAL_OP, SOFT_INT_EXEC, SVC_START} <= 3'h0;
    @(posedge CLK);
    chk("vector", {VECTOR_VALID, VECTOR}, {1'b1, e});
  endtask
  task automatic stp(input int k);
    int n;
    n = 0;
    @(posedge CLK);
    STOP_WAKE <= 1'b1;
    @(posedge CLK);
    STOP_WAKE <= 1'b0;
    do begin
      @(negedge CLK);
      n++;
    end while (STOP_RELEASE !== 1'b1 && n < 20);
    chk("stop exit", n, k);
  endtask
  task automatic rst(input logic sp, input logic cm, input logic wd, input logic [15:0] v);
    NONMASKABLE_EXT_INT_PIN_N <= 1'b0;
    CPU_X_MASK <= 1'b0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b0;
    @(negedge CLK);
    chk("nmi request", NMI_REQ, 32'h0);
    @(posedge CLK);
    {NONMASKABLE_EXT_INT_PIN_N, CPU_X_MASK, SPECIAL_MODE, CLKMON_CAUSE, WDOG_CAUSE}
      <= {2'h3, sp, cm, wd};
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (5) @(negedge CLK);
    chk("reset vector", VECTOR, v);
    rd(EVPU_IDX_INT_CTRL, 32'h60);
    rd(EVPU_IDX_PRIO_ELEV, 32'hF2);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic pulse_pin;
    @(posedge CLK);
    pin_lo <= 1'b1;
    @(posedge CLK);
    pin_lo <= 1'b0;
    @(posedge CLK);
    pin_rel <= 1'b1;
    @(posedge CLK);
    pin_rel <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  ////////////////////////////////////////
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 3; i++)
      rst(1'b0, i == 1, i == 2,
        i == 0 ? EVPU_VEC_RESET : i == 1 ? EVPU_VEC_CLKMON : EVPU_VEC_WDOG);
    rd(8'h05, 32'h0);
    stp(STOP_DLY_CYC + 1);
    @(posedge CLK);
    {NONMASKABLE_EXT_INT_PIN_N, CPU_X_MASK} <= 2'h0;
    fire(3'b001, EVPU_VEC_NMI);
    fire(3'b110, EVPU_VEC_TRAP);
    fire(3'b010, EVPU_VEC_SOFT);
    CPU_X_MASK <= 1'b1;
    fire(3'b001, EVPU_VEC_TRAP);
    NONMASKABLE_EXT_INT_PIN_N <= 1'b1;
    for (int it = 0; it < 24; it++) begin
      lfsr = lf(lfsr);
      hp = lfsr[31] ? EVPU_SRC_VEC[lfsr[27:24]] : lfsr[30] ? 8'hD4 : lfsr[23:16];
      lfsr = lf(lfsr);
      wr(EVPU_IDX_PRIO_ELEV, {24'h0, hp});
      rd(EVPU_IDX_PRIO_ELEV, {24'h0, hp});
      pend = {lfsr[14:0], lfsr[15]} & {16{it != 0}};
      @(posedge CLK);
      {raise, pin_lo, PERIPH_EN, CPU_I_MASK} <= {pend, lfsr[30:16], 1'b0};
      @(posedge CLK);
      {raise, pin_lo} <= 16'h0;
      pend[15:1] = pend[15:1] & lfsr[30:16];
      repeat (5) @(negedge CLK);
      chk("int request", INT_REQ, |pend);
      fire(3'b001, win(pend, hp));
      @(posedge CLK);
      {clear, pin_rel, CPU_I_MASK} <= {15'h7FFF, 2'h3};
      @(posedge CLK);
      {clear, pin_rel} <= 16'h0;
    end
    CPU_I_MASK <= 1'b0;
    wr(EVPU_IDX_PRIO_ELEV, {24'h0, ~hp});
    rd(EVPU_IDX_PRIO_ELEV, {24'h0, hp});
    CPU_I_MASK <= 1'b1;
    wr(EVPU_IDX_INT_CTRL, 32'h80);
    rd(EVPU_IDX_INT_CTRL, 32'h80);
    wr(EVPU_IDX_INT_CTRL, 32'h60);
    rd(EVPU_IDX_INT_CTRL, 32'hC0);
    stp(1);
    pulse_pin();
    rd(EVPU_IDX_PENDING, 32'h1);
    CPU_I_MASK <= 1'b0;
    fire(3'b001, {EVPU_VEC_HIGH_BYTE, EVPU_SRC_VEC[0]});
    CPU_I_MASK <= 1'b1;
    rd(EVPU_IDX_PENDING, 32'h0);
    rd(EVPU_IDX_LAST_VEC, {16'h0, EVPU_VEC_HIGH_BYTE, EVPU_SRC_VEC[0]});
    wr(EVPU_IDX_INT_CTRL, 32'h00);
    rd(EVPU_IDX_INT_CTRL, 32'h80);
    pulse_pin();
    rd(EVPU_IDX_PENDING, 32'h0);
    rst(1'b1, 1'b0, 1'b0, EVPU_VEC_RESET);
    wr(EVPU_IDX_INT_CTRL, 32'h80);
    rd(EVPU_IDX_INT_CTRL, 32'h00);
    wr(EVPU_IDX_INT_CTRL, 32'hE0);
    rd(EVPU_IDX_INT_CTRL, 32'hE0);
    wr(EVPU_IDX_INT_CTRL, 32'h00);
    rd(EVPU_IDX_INT_CTRL, 32'h00);
    stop_test();
  end
endmodule
bind evpu_top evpu_props #(.STOP_DLY_CYC(STOP_DLY_CYC)) u_props (
  .CLK(CLK), .RST_N(RST_N), .CPU_I_MASK(CPU_I_MASK), .CPU_X_MASK(CPU_X_MASK),
  .SVC_START(SVC_START), .SOFT_INT_EXEC(SOFT_INT_EXEC), .ILLEGAL_OP(ILLEGAL_OP),
  .STOP_WAKE(STOP_WAKE), .NONMASKABLE_EXT_INT_PIN_N(NONMASKABLE_EXT_INT_PIN_N),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .INT_REQ(INT_REQ), .NMI_REQ(NMI_REQ), .VECTOR(VECTOR), .VECTOR_VALID(VECTOR_VALID),
  .STOP_RELEASE(STOP_RELEASE));
